/* inc/dword_div_pkg.sv */
// Package: opcode fields, function codes, timing and carrier structs for the add/divide unit
package dword_div_pkg;
  // ------------------------------------------------------------
  // Instruction fields
  // ------------------------------------------------------------
  localparam logic [5:0] MAJOR_SPECIAL      = 6'h00;
  localparam logic [5:0] FN_DWORD_SUM_NT    = 6'h2d;
  localparam logic [5:0] FN_SIGNED_DWORD_Q  = 6'h1e;
  localparam logic [5:0] FN_UNSIGNED_DWORD_Q = 6'h1f;
  localparam logic [5:0] FN_SIGNED_WORD_Q   = 6'h1a;
  localparam logic [5:0] FN_UNSIGNED_WORD_Q = 6'h1b;
  localparam logic [4:0] SHAMT_ZERO         = 5'h00;
  localparam logic [9:0] DIV_PAD_ZERO       = 10'h000;
  localparam int         MAJOR_LSB          = 26;
  localparam int         SRC_A_LSB          = 21;
  localparam int         SRC_B_LSB          = 16;
  localparam int         DEST_LSB           = 11;
  localparam int         SHAMT_LSB          = 6;

  // ------------------------------------------------------------
  // Timing and reset values
  // ------------------------------------------------------------
  // One quotient bit per cycle, the last one written straight to the result registers
  localparam int          DWORD_STEPS  = 64;
  localparam int          WORD_STEPS   = 32;
  localparam logic [6:0]  STEP_CNT_RST = 7'h00;
  localparam logic [63:0] RESULT_RST   = 64'h0000_0000_0000_0000;

  typedef struct packed {
    logic        valid;
    logic [31:0] word;
    logic        mode64;
    logic        user_or_super;
  } issue_s;

  typedef struct packed {
    logic        valid;
    logic [4:0]  dest;
    logic [63:0] data;
  } wback_s;
endpackage : dword_div_pkg

/* core/dword_add_div_unit.sv */
// Doubleword no-trap add and divide slice with bottom/top result registers
//
// How it works
// - Sum decode: major zero, shamt zero, fn 101101
// - Sum of both sources written to dest
// - Sum never raises an overflow trap
// - Dword ops trap reserved in 32-bit user/super
// - Divide decode: major zero, bits 15-6 zero
// - Signed divides use two's complement operands
// - Unsigned divides use unsigned operands
// - Divides raise no arithmetic trap; zero divisor undefined
// - Quotient to bottom half, remainder top
// - Word divide uses low 32, sign-extends results
// - Results undefined until final result cycle
module dword_add_div_unit (
  input  wire logic                   clk_i,
  input  wire logic                   sys_rst_i,
  input  wire dword_div_pkg::issue_s  issue_i,
  input  wire logic [63:0]            src_a_i,
  input  wire logic [63:0]            src_b_i,
  output logic [4:0]                  src_a_field_o,
  output logic [4:0]                  src_b_field_o,
  output dword_div_pkg::wback_s       wback_o,
  output logic                        reserved_exc_o,
  output logic                        div_busy_o,
  output logic                        div_done_o,
  output logic [63:0]                 result_bottom_half_reg_o,
  output logic [63:0]                 result_top_half_reg_o
);

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } div_state_e;

  logic [5:0] major;
  logic [5:0] fn;
  logic [4:0] shamt;
  logic [9:0] div_pad;
  logic [4:0] dest;
  logic       is_sum;
  logic       is_div;
  logic       is_dword;
  logic       is_signed;
  logic       is_word;
  logic       trap_rsvd;

  assign major   = issue_i.word[31:dword_div_pkg::MAJOR_LSB];
  assign fn      = issue_i.word[5:0];
  assign shamt   = issue_i.word[10:dword_div_pkg::SHAMT_LSB];
  assign div_pad = issue_i.word[15:dword_div_pkg::SHAMT_LSB];
  assign dest    = issue_i.word[15:dword_div_pkg::DEST_LSB];

  assign is_sum = (major == dword_div_pkg::MAJOR_SPECIAL) && (shamt == dword_div_pkg::SHAMT_ZERO)
                  && (fn == dword_div_pkg::FN_DWORD_SUM_NT);
  assign is_div = (major == dword_div_pkg::MAJOR_SPECIAL) && (div_pad == dword_div_pkg::DIV_PAD_ZERO)
                  && ((fn == dword_div_pkg::FN_SIGNED_DWORD_Q) || (fn == dword_div_pkg::FN_UNSIGNED_DWORD_Q)
                  || (fn == dword_div_pkg::FN_SIGNED_WORD_Q) || (fn == dword_div_pkg::FN_UNSIGNED_WORD_Q));
  assign is_dword  = is_sum || (is_div && fn[2]);
  assign is_signed = !fn[0];
  assign is_word   = !fn[2];
  // Dword ops exist only in 64-bit mode or kernel
  assign trap_rsvd = issue_i.valid && is_dword && !issue_i.mode64 && issue_i.user_or_super;

  // ------------------------------------------------------------
  // Operand preparation
  // ------------------------------------------------------------
  logic [63:0] op_a;
  logic [63:0] op_b;
  logic        neg_q;
  logic        neg_r;
  logic        start;
  logic        accept;

  always_comb begin
    op_a  = src_a_i;
    op_b  = src_b_i;
    neg_q = 1'b0;
    neg_r = 1'b0;
    if (is_word) begin
      // Only the low word takes part in a word divide
      op_a = {{32{is_signed & src_a_i[31]}}, src_a_i[31:0]};
      op_b = {{32{is_signed & src_b_i[31]}}, src_b_i[31:0]};
    end
    if (is_signed) begin
      neg_q = op_a[63] ^ op_b[63];
      neg_r = op_a[63];
      if (op_a[63]) begin
        op_a = -op_a;
      end
      if (op_b[63]) begin
        op_b = -op_b;
      end
    end
  end

  // ------------------------------------------------------------
  // Divide engine, restoring, one bit per cycle
  // ------------------------------------------------------------
  div_state_e  state_r;
  logic [6:0]  step_r;
  logic [63:0] quo_r;
  logic [63:0] rem_r;
  logic [63:0] dvs_r;
  logic        neg_q_r;
  logic        neg_r_r;
  logic        word_r;
  logic [65:0] trial;
  logic [63:0] rem_shift;
  logic        last_step;

  // A new divide while busy is dropped; the pipeline must hold it off
  assign start     = issue_i.valid && is_div && !trap_rsvd && (state_r == ST_IDLE);
  assign accept    = issue_i.valid && is_sum && !trap_rsvd;
  assign rem_shift = {rem_r[62:0], quo_r[63]};
  // Keeps the remainder's top bit, lost for divisors above 2^63
  assign trial     = {1'b0, rem_r, quo_r[63]} - {2'b00, dvs_r};
  assign last_step = (step_r == 7'h01);

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= ST_IDLE;
      step_r  <= dword_div_pkg::STEP_CNT_RST;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            state_r <= ST_RUN;
            step_r  <= is_word ? 7'(dword_div_pkg::WORD_STEPS) : 7'(dword_div_pkg::DWORD_STEPS);
          end
        end
        ST_RUN: begin
          step_r <= step_r - 7'h01;
          if (last_step) begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          step_r  <= dword_div_pkg::STEP_CNT_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      quo_r   <= dword_div_pkg::RESULT_RST;
      rem_r   <= dword_div_pkg::RESULT_RST;
      dvs_r   <= dword_div_pkg::RESULT_RST;
      neg_q_r <= 1'b0;
      neg_r_r <= 1'b0;
      word_r  <= 1'b0;
    end else if (start) begin
      // Word divide shifts its dividend up so 32 steps suffice
      quo_r   <= is_word ? {op_a[31:0], 32'h0000_0000} : op_a;
      rem_r   <= dword_div_pkg::RESULT_RST;
      dvs_r   <= op_b;
      neg_q_r <= neg_q;
      neg_r_r <= neg_r;
      word_r  <= is_word;
    end else if (state_r == ST_RUN) begin
      // Zero divisor gives dividend remainder; all-ones quotient, or 1 for a negative signed dividend
      if (!trial[65]) begin
        rem_r <= trial[63:0];
        quo_r <= {quo_r[62:0], 1'b1};
      end else begin
        rem_r <= rem_shift;
        quo_r <= {quo_r[62:0], 1'b0};
      end
    end
  end

  // ------------------------------------------------------------
  // Result registers
  // ------------------------------------------------------------
  logic [63:0] q_fin;
  logic [63:0] r_fin;
  logic [63:0] q_last;
  logic [63:0] r_last;

  assign q_last = {quo_r[62:0], !trial[65]};
  assign r_last = trial[65] ? rem_shift : trial[63:0];

  always_comb begin
    q_fin = neg_q_r ? -q_last : q_last;
    r_fin = neg_r_r ? -r_last : r_last;
    if (word_r) begin
      q_fin = {{32{q_fin[31]}}, q_fin[31:0]};
      r_fin = {{32{r_fin[31]}}, r_fin[31:0]};
    end
  end

  // Registers change only in the result cycle, never mid-divide
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      result_bottom_half_reg_o <= dword_div_pkg::RESULT_RST;
      result_top_half_reg_o    <= dword_div_pkg::RESULT_RST;
      div_done_o               <= 1'b0;
    end else begin
      div_done_o <= (state_r == ST_RUN) && last_step;
      if ((state_r == ST_RUN) && last_step) begin
        result_bottom_half_reg_o <= q_fin;
        result_top_half_reg_o    <= r_fin;
      end
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_busy_o <= 1'b0;
    end else begin
      div_busy_o <= start || ((state_r == ST_RUN) && !last_step);
    end
  end

  // ------------------------------------------------------------
  // Sum write-back and exception
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wback_o        <= '0;
      reserved_exc_o <= 1'b0;
      src_a_field_o  <= 5'h00;
      src_b_field_o  <= 5'h00;
    end else begin
      // Carry out is discarded, no overflow path exists
      wback_o.valid  <= accept;
      wback_o.dest   <= dest;
      wback_o.data   <= src_a_i + src_b_i;
      reserved_exc_o <= trap_rsvd;
      src_a_field_o  <= issue_i.word[25:dword_div_pkg::SRC_A_LSB];
      src_b_field_o  <= issue_i.word[20:dword_div_pkg::SRC_B_LSB];
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sum_value_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    accept |=> wback_o.valid && (wback_o.data == $past(src_a_i) + $past(src_b_i)))
    else $error("sum result wrong");
  sum_decode_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    wback_o.valid |-> $past(fn) == 6'h2d && $past(shamt) == 5'h00)
    else $error("sum decoded from wrong code");
  rsvd_trap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (issue_i.valid && is_dword && !issue_i.mode64 && issue_i.user_or_super)
    |=> reserved_exc_o && !wback_o.valid)
    else $error("missing reserved trap");
  no_trap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (issue_i.valid && (is_div || is_sum) && issue_i.mode64) |=> !reserved_exc_o)
    else $error("trap in 64-bit mode");
  div_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    start |=> div_busy_o)
    else $error("divide not started");
  word_time_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (start && is_word) |-> ##33 div_done_o)
    else $error("word divide timing");
  dword_time_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (start && !is_word) |-> ##65 div_done_o)
    else $error("dword divide timing");
  hold_mid_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !div_done_o |-> $stable(result_bottom_half_reg_o) && $stable(result_top_half_reg_o))
    else $error("result changed mid-divide");
  word_sext_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (div_done_o && $past(word_r)) |-> result_bottom_half_reg_o[63:32] == {32{result_bottom_half_reg_o[31]}}
    && result_top_half_reg_o[63:32] == {32{result_top_half_reg_o[31]}})
    else $error("word result not sign-extended");
  udiv_val_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (start && fn == 6'h1f && op_b != 64'h0)
    |-> ##65 result_bottom_half_reg_o == $past(op_a, 65) / $past(op_b, 65)
    && result_top_half_reg_o == $past(op_a, 65) % $past(op_b, 65))
    else $error("unsigned divide wrong");
  sdiv_val_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (start && fn == 6'h1a && src_b_i[31:0] != 32'h0
     && !(src_a_i[31:0] == 32'h8000_0000 && src_b_i[31:0] == 32'hffff_ffff))
    |-> ##33 result_bottom_half_reg_o[31:0]
    == 32'($signed($past(src_a_i[31:0], 33)) / $signed($past(src_b_i[31:0], 33))))
    else $error("signed word divide wrong");
  done_pulse_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    div_done_o |=> !div_done_o)
    else $error("done held over two cycles");
  busy_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    div_done_o |-> !div_busy_o)
    else $error("busy high with done");
  word_no_trap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (issue_i.valid && is_div && !is_dword) |=> !reserved_exc_o)
    else $error("word divide trapped");
  zero_quot_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    (start && fn == 6'h1f && op_b == 64'h0) |-> ##65 result_bottom_half_reg_o == 64'hffff_ffff_ffff_ffff)
    else $error("zero divisor quotient wrong");
  sum_dest_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    accept |=> wback_o.dest == $past(issue_i.word[15:11]))
    else $error("sum destination wrong");
  src_field_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    issue_i.valid |=> src_a_field_o == $past(issue_i.word[25:21]) && src_b_field_o == $past(issue_i.word[20:16]))
    else $error("source fields wrong");

endmodule : dword_add_div_unit

/* test/issue_stage_model.sv */
// Partner model: decode stage and register-file read port feeding the unit
module issue_stage_model (
  input  wire logic                  clk_i,
  output dword_div_pkg::issue_s      issue_o,
  output logic [63:0]                src_a_o,
  output logic [63:0]                src_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    issue_o = '0;
    src_a_o = 64'h0;
    src_b_o = 64'h0;
  end
  // Caller sits just after an edge; holds one edge, returns just after it
  task automatic send(input logic [31:0] w, input logic [63:0] a, input logic [63:0] b, input logic m64,
                      input logic us);
    issue_o = '{valid: 1'b1, word: w, mode64: m64, user_or_super: us};
    src_a_o = a;
    src_b_o = b;
    @(posedge clk_i);
    #1;
  endtask : send
  // Released word and operand lines show the inverse of their last value; mode64 and user_or_super keep theirs
  task automatic idle();
    issue_o.valid = 1'b0;
    issue_o.word  = ~issue_o.word;
    src_a_o       = ~src_a_o;
    src_b_o       = ~src_b_o;
    @(posedge clk_i);
    #1;
  endtask : idle
endmodule : issue_stage_model

/* test/tb_dword_add_and_divide_unit.sv */
// Testbench: sums, traps, decode misses and all four divides with a result scoreboard
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb_dword_add_and_divide_unit;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  dword_div_pkg::issue_s issue;
  logic [63:0] src_a, src_b, bot, top;
  logic [4:0]  fa, fb;
  dword_div_pkg::wback_s wb;
  logic        exc, busy, done;
  logic [78:0] sum_q[$];
  logic [127:0] div_q[$];
  logic [78:0] se;
  logic [127:0] de;
  int error_cnt = 0, checks = 0, exp_trap = 0, seen_trap = 0, cyc = 0;
  logic [31:0] seed = 32'h1799;
  always #2.5 clk_i = ~clk_i;
  issue_stage_model u_issue_stage_model (.clk_i(clk_i), .issue_o(issue), .src_a_o(src_a), .src_b_o(src_b));
  dword_add_div_unit u_dword_add_div_unit (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .issue_i(issue),
    .src_a_i(src_a), .src_b_i(src_b), .src_a_field_o(fa), .src_b_field_o(fb), .wback_o(wb),
    .reserved_exc_o(exc), .div_busy_o(busy), .div_done_o(done), .result_bottom_half_reg_o(bot),
    .result_top_half_reg_o(top));
  function automatic logic [63:0] rnd();
    logic [31:0] h;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    h = seed;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return {h, seed};
  endfunction : rnd
  function automatic logic [31:0] iw(input logic [4:0] a, b, d, sh, input logic [5:0] fn);
    return {dword_div_pkg::MAJOR_SPECIAL, a, b, d, sh, fn};
  endfunction : iw
  // Zero divisor: all-ones quotient, dividend as remainder (positive dividend only)
  function automatic logic [127:0] div_exp(input logic [5:0] fn, input logic [63:0] a, b);
    logic [63:0] q, r;
    logic [31:0] q32, r32;
    case (fn)
      dword_div_pkg::FN_SIGNED_DWORD_Q: begin
        q = (b == 64'h0) ? '1 : 64'($signed(a) / $signed(b));
        r = (b == 64'h0) ? a : 64'($signed(a) % $signed(b));
      end
      dword_div_pkg::FN_UNSIGNED_DWORD_Q: begin
        q = (b == 64'h0) ? '1 : a / b;
        r = (b == 64'h0) ? a : a % b;
      end
      default: begin
        if (b[31:0] == 32'h0) begin
          q32 = '1;
          r32 = a[31:0];
        end else if (fn == dword_div_pkg::FN_SIGNED_WORD_Q) begin
          q32 = 32'($signed(a[31:0]) / $signed(b[31:0]));
          r32 = 32'($signed(a[31:0]) % $signed(b[31:0]));
        end else begin
          q32 = a[31:0] / b[31:0];
          r32 = a[31:0] % b[31:0];
        end
        q = {{32{q32[31]}}, q32};
        r = {{32{r32[31]}}, r32};
      end
    endcase
    return {r, q};
  endfunction : div_exp
  task automatic test_done();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  task automatic sum(input logic [4:0] d, input logic [63:0] a, b, input logic us);
    logic [4:0] ra, rb;
    ra = 5'(rnd());
    rb = 5'(rnd());
    sum_q.push_back({d, ra, rb, a + b});
    u_issue_stage_model.send(iw(ra, rb, d, dword_div_pkg::SHAMT_ZERO, dword_div_pkg::FN_DWORD_SUM_NT), a, b, 1'b1, us);
  endtask : sum
  // Result must appear exactly N cycles after issue, not one earlier
  task automatic div(input logic [5:0] fn, input logic [63:0] a, b, input logic m64, input logic again);
    int n;
    n = (fn == dword_div_pkg::FN_SIGNED_WORD_Q || fn == dword_div_pkg::FN_UNSIGNED_WORD_Q) ? 32 : 64;
    div_q.push_back(div_exp(fn, a, b));
    u_issue_stage_model.send(iw(5'h3, 5'h4, 5'h0, 5'h0, fn), a, b, m64, 1'b0);
    if (again) begin
      u_issue_stage_model.send(iw(5'h5, 5'h6, 5'h0, 5'h0, fn), ~a, b, m64, 1'b0);
      n--;
    end
    u_issue_stage_model.idle();
    repeat (n - 2) @(posedge clk_i);
    #1;
    `CHK({busy, done}, 2'b10)
    @(posedge clk_i);
    #1;
    `CHK({busy, done}, 2'b01)
    repeat (2) u_issue_stage_model.idle();
  endtask : div
  always @(negedge clk_i) begin
    if (!sys_rst_i) begin
      if (exc === 1'b1) seen_trap++;
      if (wb.valid !== 1'b0) begin
        se = (sum_q.size() > 0) ? sum_q.pop_front() : 'x;
        `CHK({wb.dest, fa, fb, wb.data}, se)
      end
      if (done !== 1'b0) begin
        de = (div_q.size() > 0) ? div_q.pop_front() : 'x;
        `CHK({top, bot}, de)
      end
    end
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    logic [63:0] x, y;
    logic [5:0]  fns [4];
    fns = '{dword_div_pkg::FN_SIGNED_DWORD_Q, dword_div_pkg::FN_UNSIGNED_DWORD_Q,
            dword_div_pkg::FN_SIGNED_WORD_Q, dword_div_pkg::FN_UNSIGNED_WORD_Q};
    repeat (16) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    sum(5'h1f, 64'h7fff_ffff_ffff_ffff, 64'h1, 1'b1);
    for (int i = 0; i < 6; i++) sum(5'(i), rnd(), rnd(), 1'(i));
    u_issue_stage_model.idle();
    $display("test sums done");
    u_issue_stage_model.send(iw(5'h1, 5'h2, 5'h3, 5'h1, dword_div_pkg::FN_DWORD_SUM_NT), 1, 2, 1'b1, 1'b0);
    u_issue_stage_model.send(iw(5'h1, 5'h2, 5'h8, 5'h0, dword_div_pkg::FN_UNSIGNED_DWORD_Q), 9, 2, 1'b1, 1'b0);
    u_issue_stage_model.idle();
    repeat (70) @(posedge clk_i);
    #1;
    $display("test decode misses done");
    for (int i = 0; i < 3; i++) begin
      u_issue_stage_model.send(iw(5'h1, 5'h2, 5'h0, 5'h0, i == 0 ? dword_div_pkg::FN_DWORD_SUM_NT : fns[i - 1]),
                               rnd(), 64'h7, 1'b0, 1'b1);
      exp_trap++;
    end
    u_issue_stage_model.idle();
    x = 64'(signed'(32'(rnd())));
    div(dword_div_pkg::FN_SIGNED_WORD_Q, x, 64'h3, 1'b0, 1'b0);
    div(dword_div_pkg::FN_UNSIGNED_DWORD_Q, 64'h64, 64'h7, 1'b0, 1'b0);
    $display("test traps done");
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 3; i++) begin
        x = rnd();
        y = rnd() >> (i * 20) | 64'h1;
        if (k > 1) begin
          x = 64'(signed'(x[31:0]));
          y = 64'(signed'(y[31:0] | 32'h1));
        end
        div(fns[k], x, y, 1'b1, 1'b0);
      end
      div(fns[k], 64'h1234, 64'h0, 1'b1, 1'b0);
    end
    $display("test divides done");
    div(dword_div_pkg::FN_UNSIGNED_WORD_Q, 64'h64, 64'h7, 1'b1, 1'b1);
    $display("test busy drop done");
    repeat (4) @(posedge clk_i);
    #1;
    `CHK(seen_trap, exp_trap)
    `CHK(sum_q.size() + div_q.size(), 0)
    test_done();
  end
endmodule : tb_dword_add_and_divide_unit
